//--- logic/udcr_cfg.svh
`ifndef UDCR_CFG_SVH
`define UDCR_CFG_SVH
// Command codes
`define UDCR_CMD_EP_WR_BASE 8'h20
`define UDCR_CMD_EP_RD_BASE 8'h30
`define UDCR_CMD_ADDR_WR 8'hb6
`define UDCR_CMD_ADDR_RD 8'hb7
`define UDCR_CMD_MODE_WR 8'hb8
`define UDCR_CMD_MODE_RD 8'hb9
`define UDCR_CMD_HWCFG_WR 8'hba
`define UDCR_CMD_HWCFG_RD 8'hbb
`define UDCR_LAST_EP 4'hf
// Endpoint configuration fields
`define UDCR_EP_ENABLE_BIT 7
`define UDCR_EP_DIR_BIT 6
`define UDCR_EP_DBL_BIT 5
`define UDCR_EP_ISO_BIT 4
// Device address fields
`define UDCR_ADDR_EN_BIT 7
`define UDCR_ADDR_DEFAULT 7'h00
// Mode fields
`define UDCR_MODE_SUSP_BIT 5
`define UDCR_MODE_INTEN_BIT 3
`define UDCR_MODE_DBG_BIT 2
`define UDCR_MODE_SOFT_BIT 0
`define UDCR_MODE_RESET 8'h80
`define UDCR_MODE_WMASK 8'h2d
`define UDCR_MODE_KEEP 8'h8f
// Hardware configuration fields
`define UDCR_HW_EXTPU_BIT 14
`define UDCR_HW_NOSLOW_BIT 13
`define UDCR_HW_CLKON_BIT 12
`define UDCR_HW_DIV_LSB 8
`define UDCR_HW_INTPULSE_BIT 1
`define UDCR_HW_INT_POLARITY_BIT 0
`define UDCR_HW_RESET 16'h2344
`define UDCR_HW_WMASK 16'h7feb
// Timing
`define UDCR_CLK_HZ 40000000
`define UDCR_INT_PULSE_NS 166
`define UDCR_SUSPEND_DELAY_US 2000
`endif

//--- logic/udcr_pkg.sv
`default_nettype none
package udcr_pkg;
  typedef enum logic [1:0] {
    UDCR_IDLE = 2'b00,
    UDCR_LOW = 2'b01,
    UDCR_HIGH = 2'b10
  } udcr_phase_t;
  typedef enum logic [1:0] {
    UDCR_AWAKE = 2'b00,
    UDCR_WAIT = 2'b01,
    UDCR_ASLEEP = 2'b10
  } udcr_susp_t;
endpackage
`default_nettype wire

//--- logic/udcr_clkdiv.sv
`default_nettype none
// Divides a 48 MHz reference by (divider + 1) for divider 1 to 15, holds high at 0; new value taken only at period end
module udcr_clkdiv
  import udcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] divider,
  output logic clk_out
);
  logic [1:0] rst_s_r;
  logic [3:0] div_s1_r;
  logic [3:0] div_s2_r;
  logic [3:0] div_s3_r;
  logic [3:0] div_r;
  logic [3:0] cnt_r;
  logic clk_out_r;
  // Reset and divider come from the controller clock: two flops for reset, three for the divider
  always_ff @(posedge clk) begin
    rst_s_r <= {rst_s_r[0], rst};
    div_s1_r <= divider;
    div_s2_r <= div_s1_r;
    div_s3_r <= div_s2_r;
  end
  wire logic rst_sync = rst_s_r[1];
  // Multi-bit word: taken only once two synchronised samples agree
  wire logic div_steady = (div_s2_r == div_s3_r);
  wire logic period_end = (cnt_r == div_r);
  always_ff @(posedge clk) begin
    if (rst_sync) begin
      div_r <= 4'h3;
      cnt_r <= 4'h0;
      clk_out_r <= 1'b0;
    end else if (ce) begin
      if (period_end) begin
        cnt_r <= 4'h0;
        if (div_steady) begin
          div_r <= div_s3_r; // Glitch-free: load only between periods
        end
        clk_out_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == {1'b0, div_r[3:1]}) begin
          clk_out_r <= 1'b0;
        end
      end
    end
  end
  assign clk_out = clk_out_r; // Frequency is 48 MHz / (divider + 1) for divider 1 to 15; divider 0 holds it high
endmodule // udcr_clkdiv
`default_nettype wire

//--- logic/udcr_regs.sv
`include "udcr_cfg.svh"
`default_nettype none
// Functional notes
// - Allocate buffers after endpoint 15 in sequence
// - Memory-affecting change invalidates all buffers
// - Endpoint config codes 20-2F write, 30-3F read
// - Bit 7 enables endpoint buffer
// - Bit 6 sets direction and DMA direction
// - Bit 5 double buffer, bit 4 isochronous
// - Low nibble is buffer size code
// - Address register B6/B7, enable plus address
// - Bus reset: internal address zero, enabled
// - New address active after status ACK
// - Mode register B8/B9, upper byte ignored
// - Suspend on mode bit 5 one then zero
// - Mode bit 3 gates all interrupts
// - Debug mode: interrupts on NAK and error
// - Soft pull-up ignored if external or dual-role
// - Mode resets to 80h, keeps bits across bus reset
// - Hardware config BA/BB, bus reset leaves it
// - Hardware config field positions
// - Output clock 48/(N+1), glitch free; N = 0 holds the output high instead
// - Pulsed interrupt 166 ns, else level with polarity
// - Clocks stop 2 ms after suspend trigger
module udcr_regs
  import udcr_pkg::*;
#(
  parameter int NUM_EP = 16,
  parameter int SUSPEND_CYCLES = (`UDCR_SUSPEND_DELAY_US * (`UDCR_CLK_HZ / 1000000))
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clk48,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [15:0] data_in,
  input wire logic bus16,
  output logic [15:0] data_out,
  input wire logic usb_bus_reset,
  input wire logic status_acked,
  input wire logic dual_role_mode,
  input wire logic int_event_ack,
  input wire logic int_event_nak,
  input wire logic int_event_err,
  input wire logic int_event_iso,
  input wire logic int_event_other,
  output logic alloc_start,
  output logic buffers_invalid,
  output logic [127:0] ep_config_flat,
  output logic [6:0] active_address,
  output logic active_enable,
  output logic suspend_req,
  output logic clocks_stopped,
  output logic slow_clock_sel,
  output logic pullup_on,
  output logic int_out,
  output logic clock_output_pin
);
  localparam int INT_PULSE_CYCLES =
    (`UDCR_INT_PULSE_NS * (`UDCR_CLK_HZ / 1000000) + 999) / 1000;

  // Bus reset and the status acknowledge from the USB side arrive asynchronously
  logic [1:0] bres_s_r;
  logic [1:0] ack_s_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      bres_s_r <= 2'b00;
      ack_s_r <= 2'b00;
    end else if (ce) begin
      bres_s_r <= {bres_s_r[0], usb_bus_reset};
      ack_s_r <= {ack_s_r[0], status_acked};
    end
  end
  wire logic bus_reset = bres_s_r[1];
  wire logic host_ack = ack_s_r[1];

  // Command decode
  logic [7:0] cmd_r;
  logic phase_hi_r;
  wire logic is_ep_wr = (cmd_r[7:4] == 4'(`UDCR_CMD_EP_WR_BASE >> 4));
  wire logic is_ep_rd = (cmd_r[7:4] == 4'(`UDCR_CMD_EP_RD_BASE >> 4));
  wire logic [3:0] ep_idx = cmd_r[3:0];
  wire logic is_addr_wr = (cmd_r == `UDCR_CMD_ADDR_WR);
  wire logic is_mode_wr = (cmd_r == `UDCR_CMD_MODE_WR);
  wire logic is_hw_wr = (cmd_r == `UDCR_CMD_HWCFG_WR);
  wire logic wr_ep = ce && data_wr && is_ep_wr;
  wire logic wr_addr = ce && data_wr && is_addr_wr;
  wire logic wr_mode = ce && data_wr && is_mode_wr;
  wire logic wr_hw_lo = ce && data_wr && is_hw_wr && (bus16 || !phase_hi_r);
  wire logic wr_hw_hi = ce && data_wr && is_hw_wr && (bus16 || phase_hi_r);
  wire logic [7:0] hw_hi_byte = bus16 ? data_in[15:8] : data_in[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_r <= 8'h00;
      phase_hi_r <= 1'b0;
    end else if (ce) begin
      if (cmd_valid) begin
        cmd_r <= cmd_code;
        phase_hi_r <= 1'b0;
      end else if ((data_wr || data_rd) && !bus16) begin
        phase_hi_r <= ~phase_hi_r;
      end
    end
  end

  // Endpoint configuration store
  logic [7:0] ep_cfg_r [NUM_EP];
  logic [3:0] seq_r;
  logic alloc_r;
  logic inval_r;
  wire logic [7:0] ep_old = ep_cfg_r[ep_idx];
  // Size or enable change affects allocated memory
  wire logic mem_change = (ep_old[7] != data_in[7]) || (ep_old[3:0] != data_in[3:0]);
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_cfg_r[i] <= 8'h00;
      end
      seq_r <= 4'h0;
      alloc_r <= 1'b0;
      inval_r <= 1'b0;
    end else if (ce) begin
      alloc_r <= 1'b0;
      if (bus_reset) begin
        for (int i = 0; i < NUM_EP; i++) begin
          ep_cfg_r[i][`UDCR_EP_ENABLE_BIT] <= 1'b0;
        end
        seq_r <= 4'h0;
      end else if (wr_ep) begin
        ep_cfg_r[ep_idx] <= data_in[7:0];
        if (mem_change) begin
          inval_r <= 1'b1;
        end
        // Out-of-order write restarts the sequence
        if (ep_idx == seq_r) begin
          seq_r <= seq_r + 4'h1;
          if (ep_idx == `UDCR_LAST_EP) begin
            alloc_r <= 1'b1;
            inval_r <= 1'b0;
          end
        end else begin
          seq_r <= (ep_idx == 4'h0) ? 4'h1 : 4'h0;
        end
      end
    end
  end
  assign alloc_start = alloc_r;
  assign buffers_invalid = inval_r;
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      ep_config_flat[i*8 +: 8] = ep_cfg_r[i];
    end
  end

  // Device address: register value versus address in use
  logic [7:0] addr_r;
  logic [6:0] act_addr_r;
  logic act_en_r;
  logic addr_pend_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= 8'h00;
      act_addr_r <= `UDCR_ADDR_DEFAULT;
      act_en_r <= 1'b0;
      addr_pend_r <= 1'b0;
    end else if (ce) begin
      if (bus_reset) begin
        act_addr_r <= `UDCR_ADDR_DEFAULT;
        act_en_r <= 1'b1;
        addr_pend_r <= 1'b0;
      end else if (addr_pend_r && host_ack) begin
        act_addr_r <= addr_r[6:0];
        act_en_r <= addr_r[`UDCR_ADDR_EN_BIT];
        addr_pend_r <= 1'b0;
      end
      // A write in the same cycle stays pending: set wins over clear
      if (wr_addr) begin
        addr_r <= data_in[7:0];
        addr_pend_r <= 1'b1;
      end
    end
  end
  assign active_address = act_addr_r;
  assign active_enable = act_en_r;

  // Mode and hardware configuration
  logic [7:0] mode_r;
  logic [15:0] hw_r;
  localparam logic [15:0] HW_WMASK = `UDCR_HW_WMASK;
  wire logic [7:0] mode_wr_val = (data_in[7:0] & `UDCR_MODE_WMASK) | (mode_r & ~`UDCR_MODE_WMASK);
  wire logic susp_fall = wr_mode && mode_r[`UDCR_MODE_SUSP_BIT] && !data_in[`UDCR_MODE_SUSP_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= `UDCR_MODE_RESET;
      hw_r <= `UDCR_HW_RESET;
    end else if (ce) begin
      if (wr_mode) begin
        mode_r <= mode_wr_val; // Upper byte dropped
      end else if (bus_reset) begin
        mode_r <= mode_r & `UDCR_MODE_KEEP;
      end
      // No bus reset term here: never altered by it
      if (wr_hw_lo) begin
        hw_r[7:0] <= (data_in[7:0] & HW_WMASK[7:0]) | (hw_r[7:0] & ~HW_WMASK[7:0]);
      end
      if (wr_hw_hi) begin
        hw_r[15:8] <= (hw_hi_byte & HW_WMASK[15:8]) | (hw_r[15:8] & ~HW_WMASK[15:8]);
      end
    end
  end
  wire logic ext_pu = hw_r[`UDCR_HW_EXTPU_BIT];
  wire logic no_slow = hw_r[`UDCR_HW_NOSLOW_BIT];
  wire logic clk_on = hw_r[`UDCR_HW_CLKON_BIT];
  wire logic [3:0] ck_div = hw_r[`UDCR_HW_DIV_LSB +: 4];
  assign pullup_on = mode_r[`UDCR_MODE_SOFT_BIT] && !ext_pu && !dual_role_mode;

  // Suspend sequencing
  udcr_susp_t susp_r;
  logic [31:0] susp_cnt_r;
  logic susp_req_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      susp_r <= UDCR_AWAKE;
      susp_cnt_r <= 32'h0;
      susp_req_r <= 1'b0;
    end else if (ce) begin
      susp_req_r <= susp_fall;
      case (susp_r)
        UDCR_AWAKE: begin
          if (susp_fall) begin
            susp_r <= UDCR_WAIT;
            susp_cnt_r <= 32'h0;
          end
        end
        UDCR_WAIT: begin
          if (bus_reset) begin
            susp_r <= UDCR_AWAKE;
          end else if (susp_cnt_r == 32'(SUSPEND_CYCLES - 1)) begin
            susp_r <= UDCR_ASLEEP;
          end else begin
            susp_cnt_r <= susp_cnt_r + 32'h1;
          end
        end
        UDCR_ASLEEP: begin
          if (bus_reset || wr_mode) begin
            susp_r <= UDCR_AWAKE;
          end
        end
        default: susp_r <= UDCR_AWAKE;
      endcase
    end
  end
  assign suspend_req = susp_req_r;
  assign clocks_stopped = (susp_r == UDCR_ASLEEP) && !clk_on;
  assign slow_clock_sel = (susp_r == UDCR_ASLEEP) && !no_slow;

  // Interrupt source selection and output shaping
  wire logic dbg = mode_r[`UDCR_MODE_DBG_BIT];
  wire logic int_src = dbg ? (int_event_nak || int_event_err)
                           : (int_event_ack || int_event_iso);
  wire logic int_fire = mode_r[`UDCR_MODE_INTEN_BIT] && (int_src || int_event_other);
  logic int_lvl_r;
  logic [7:0] pulse_cnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      int_lvl_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
    end else if (ce) begin
      if (!mode_r[`UDCR_MODE_INTEN_BIT]) begin
        int_lvl_r <= 1'b0;
        pulse_cnt_r <= 8'h00;
      end else if (int_fire) begin
        int_lvl_r <= 1'b1; // Set wins over the read clear
        pulse_cnt_r <= 8'(INT_PULSE_CYCLES);
      end else begin
        if (data_rd) begin
          int_lvl_r <= 1'b0;
        end
        if (pulse_cnt_r != 8'h00) begin
          pulse_cnt_r <= pulse_cnt_r - 8'h01;
        end
      end
    end
  end
  wire logic int_act = hw_r[`UDCR_HW_INTPULSE_BIT] ? (pulse_cnt_r != 8'h00) : int_lvl_r;
  logic int_out_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      // Inactive level of the reset polarity (active low): no false interrupt
      int_out_r <= 1'b1;
    end else if (ce) begin
      int_out_r <= int_act ~^ hw_r[`UDCR_HW_INT_POLARITY_BIT];
    end
  end
  assign int_out = int_out_r;

  // Read data
  wire logic [15:0] rd_sel =
    is_ep_rd ? {8'h00, ep_cfg_r[ep_idx]} :
    (cmd_r == `UDCR_CMD_ADDR_RD) ? {8'h00, addr_r} :
    (cmd_r == `UDCR_CMD_MODE_RD) ? {8'h00, mode_r} :
    (cmd_r == `UDCR_CMD_HWCFG_RD) ? ((bus16 || !phase_hi_r) ? hw_r : {8'h00, hw_r[15:8]}) :
    16'h0000;
  logic [15:0] dout_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_r <= 16'h0000;
    end else if (ce) begin
      dout_r <= rd_sel;
    end
  end
  assign data_out = dout_r;

  udcr_clkdiv u_clkdiv (
    .clk(clk48),
    .rst(rst),
    .ce(1'b1),
    .divider(ck_div),
    .clk_out(clock_output_pin)
  );

  // Assertions
  sequence s_last_in_order;
    wr_ep && ep_idx == `UDCR_LAST_EP && seq_r == `UDCR_LAST_EP && !bus_reset;
  endsequence
  property p_alloc;
    @(posedge clk) disable iff (rst) s_last_in_order |=> alloc_start;
  endproperty
  a_alloc: assert property (p_alloc) else $error("Allocation not started");
  property p_alloc_only;
    @(posedge clk) disable iff (rst) alloc_start |-> $past(wr_ep);
  endproperty
  a_alloc_only: assert property (p_alloc_only) else $error("Spurious allocation");
  property p_addr_hold;
    @(posedge clk) disable iff (rst) (bus_reset && ce && !wr_addr) |=> $stable(addr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Address reg hit by reset");
  property p_addr_def;
    @(posedge clk) disable iff (rst) (bus_reset && ce) |=> active_enable && active_address == 7'h00;
  endproperty
  a_addr_def: assert property (p_addr_def) else $error("Bus reset address wrong");
  property p_inten;
    @(posedge clk) disable iff (rst) !mode_r[3] |=> ##1 int_out == !hw_r[0] || $changed(hw_r);
  endproperty
  a_inten: assert property (p_inten) else $error("Interrupt while disabled");
  property p_hw_keep;
    @(posedge clk) disable iff (rst) (bus_reset && !wr_hw_lo && !wr_hw_hi) |=> $stable(hw_r);
  endproperty
  a_hw_keep: assert property (p_hw_keep) else $error("Hw config hit by reset");
  property p_mode_resv;
    @(posedge clk) disable iff (rst) mode_r[7] && mode_r[6:4] ==? 3'b0x0 && !mode_r[1];
  endproperty
  a_mode_resv: assert property (p_mode_resv) else $error("Mode reserved bits moved");
  property p_pullup;
    @(posedge clk) disable iff (rst) (ext_pu || dual_role_mode) |-> !pullup_on;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up not suppressed");
endmodule // udcr_regs
`default_nettype wire

//--- testbench/udcr_host_model.sv
`default_nettype none
module udcr_host_model (
  input wire logic clk,
  input wire logic bus16,
  input wire logic [15:0] data_out,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic data_wr,
  output logic data_rd,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    data_wr = 1'b0;
    data_rd = 1'b0;
    data_in = 16'h0000;
  end
  // Code stroke, then nb data strokes, low byte first on a narrow bus
  // Callers sequence endpoints from control OUT, drain before resizing
  // Address write precedes status ack; suspend needs both writes
  task automatic wr(input logic [7:0] code, input logic [15:0] d, input int nb);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      data_wr <= 1'b1;
      data_in <= (i == 0) ? d : {d[7:0], d[15:8]};
    end
    @(posedge clk);
    data_wr <= 1'b0;
    cmd_code <= ~code;
    // Released bus shows a changing pattern, not the last value
    data_in <= ~data_in;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    data_rd <= 1'b1;
    @(posedge clk);
    data_rd <= 1'b0;
    cmd_code <= ~code;
    @(posedge clk);
    #1 q = data_out;
  endtask
endmodule // udcr_host_model
`default_nettype wire

//--- testbench/testbench.sv
`include "udcr_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUSP = 20;
  logic clk, rst, ce, clk48, bus16, usb_bus_reset, status_acked, dual_role_mode, pol;
  logic [4:0] ev;
  logic cmd_valid, data_wr, data_rd, alloc_start, buffers_invalid, active_enable, suspend_req;
  logic clocks_stopped, slow_clock_sel, pullup_on, int_out, cko;
  logic [7:0] cmd_code;
  logic [15:0] data_in, data_out, q, w;
  logic [127:0] ep_cfg;
  logic [6:0] act_addr;
  logic [7:0] cfg [16];
  int num_errors = 0, n_compared = 0, allocs = 0, susps = 0, seed, s0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    clk48 = 1'b0;
    forever #10.4167 clk48 = ~clk48;
  end
  always @(posedge clk) begin
    if (alloc_start === 1'b1) allocs <= allocs + 1;
    if (suspend_req === 1'b1) susps <= susps + 1;
  end
  udcr_host_model host_i (.clk(clk), .bus16(bus16), .data_out(data_out), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in));
  udcr_regs #(.SUSPEND_CYCLES(SUSP)) udcr_regs_i (.clk(clk), .rst(rst), .ce(ce), .clk48(clk48),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_wr(data_wr), .data_rd(data_rd),
    .data_in(data_in), .bus16(bus16), .data_out(data_out), .usb_bus_reset(usb_bus_reset),
    .status_acked(status_acked), .dual_role_mode(dual_role_mode), .int_event_ack(ev[0]),
    .int_event_nak(ev[1]), .int_event_err(ev[2]), .int_event_iso(ev[3]),
    .int_event_other(ev[4]), .alloc_start(alloc_start), .buffers_invalid(buffers_invalid),
    .ep_config_flat(ep_cfg), .active_address(act_addr), .active_enable(active_enable),
    .suspend_req(suspend_req), .clocks_stopped(clocks_stopped),
    .slow_clock_sel(slow_clock_sel), .pullup_on(pullup_on), .int_out(int_out),
    .clock_output_pin(cko));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] code, input logic [15:0] e, input logic [15:0] m);
    host_i.rd(code, q);
    chk(q & m, e);
  endtask
  function automatic logic [15:0] exp_mode(input logic [15:0] d);
    return {8'h00, (d[7:0] & `UDCR_MODE_WMASK) | `UDCR_MODE_RESET};
  endfunction
  function automatic logic [15:0] exp_hw(input logic [15:0] d);
    return (d & `UDCR_HW_WMASK) | (`UDCR_HW_RESET & ~`UDCR_HW_WMASK);
  endfunction
  task automatic busrst();
    usb_bus_reset <= 1'b1;
    repeat (4) @(posedge clk);
    usb_bus_reset <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic irq(input logic [7:0] md, input int k, input logic hit);
    host_i.wr(`UDCR_CMD_MODE_WR, {8'h00, md}, 1);
    ev <= 5'(1 << k);
    @(posedge clk);
    ev <= 5'h00;
    repeat (4) @(posedge clk);
    #1 chk(16'(int_out), {15'h0000, (hit ? pol : !pol)});
    host_i.rd(`UDCR_CMD_MODE_RD, q);
    repeat (2) @(posedge clk);
    #1 chk(16'(int_out), {15'h0000, !pol});
  endtask
  task automatic per(input int n);
    realtime t1, d;
    repeat (3) @(posedge cko);
    t1 = $realtime;
    @(posedge cko);
    d = $realtime - t1 - (n + 1) * 20.8333;
    n_compared++;
    if (d > 1.0 || d < -1.0) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, $rtoi($realtime - t1), (n + 1) * 21);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #300us;
    num_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 0, 1);
    end_sim();
  end
  initial begin
    seed = 32'h39000746;
    rst = 1'b1;
    ce = 1'b1;
    bus16 = 1'b1;
    usb_bus_reset = 1'b0;
    status_acked = 1'b0;
    dual_role_mode = 1'b0;
    ev = 5'h00;
    pol = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(`UDCR_CMD_MODE_RD, 16'h0080, 16'h00ff);
    rc(`UDCR_CMD_HWCFG_RD, 16'h2344, 16'hffff);
    rc(`UDCR_CMD_ADDR_RD, 16'h0000, 16'h00ff);
    for (int i = 0; i < 16; i++) rc(8'h30 + 8'(i), 16'h0000, 16'h00ff);
    repeat (6) begin
      w = 16'($random(seed));
      host_i.wr(`UDCR_CMD_MODE_WR, w, 1);
      rc(`UDCR_CMD_MODE_RD, exp_mode(w), 16'h00ff);
      w = 16'($random(seed));
      host_i.wr(`UDCR_CMD_HWCFG_WR, w, 1);
      rc(`UDCR_CMD_HWCFG_RD, exp_hw(w), 16'hffff);
    end
    rc(8'hc5, 16'h0000, 16'hffff);
    bus16 <= 1'b0;
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h5a21, 2);
    bus16 <= 1'b1;
    rc(`UDCR_CMD_HWCFG_RD, exp_hw(16'h5a21), 16'hffff);
    $display("register test done");
    for (int i = 0; i < 16; i++) cfg[i] = 8'($random(seed)) | 8'h80;
    cfg[0] = 8'h83;
    cfg[1] = 8'hc3;
    // Restart in mid-sequence must not allocate
    for (int i = 0; i < 15; i++) host_i.wr(8'h20 + 8'(i), {8'h00, cfg[i]}, 1);
    host_i.wr(8'h23, {8'h00, cfg[3]}, 1);
    host_i.wr(8'h2f, {8'h00, cfg[15]}, 1);
    repeat (10) @(posedge clk);
    chk(16'(allocs), 16'h0000);
    for (int i = 0; i < 16; i++) host_i.wr(8'h20 + 8'(i), {8'h00, cfg[i]}, 1);
    repeat (10) @(posedge clk);
    chk(16'(allocs), 16'h0001);
    chk(16'(buffers_invalid), 16'h0000);
    for (int i = 0; i < 16; i++) begin
      rc(8'h30 + 8'(i), {8'h00, cfg[i]}, 16'h00ff);
      chk({8'h00, ep_cfg[8*i +: 8]}, {8'h00, cfg[i]});
    end
    host_i.wr(8'h25, {8'h00, cfg[5] ^ 8'h01}, 1);
    repeat (3) @(posedge clk);
    chk(16'(buffers_invalid), 16'h0001);
    $display("endpoint test done");
    host_i.wr(`UDCR_CMD_MODE_WR, 16'h002d, 1);
    busrst();
    chk({8'h00, active_enable, act_addr}, 16'h0080);
    chk(16'(ep_cfg[7]), 16'h0000);
    rc(`UDCR_CMD_MODE_RD, 16'h008d, 16'h00ff);
    rc(`UDCR_CMD_HWCFG_RD, exp_hw(16'h5a21), 16'hffff);
    w = 16'h0081 | 16'($random(seed) & 32'h7e);
    host_i.wr(`UDCR_CMD_ADDR_WR, w, 1);
    repeat (5) @(posedge clk);
    chk({9'h000, act_addr}, 16'h0000);
    status_acked <= 1'b1;
    repeat (3) @(posedge clk);
    status_acked <= 1'b0;
    repeat (5) @(posedge clk);
    chk({8'h00, active_enable, act_addr}, w);
    busrst();
    chk({8'h00, active_enable, act_addr}, 16'h0080);
    rc(`UDCR_CMD_ADDR_RD, w, 16'h00ff);
    $display("address test done");
    // Clocks may stop and slow clock allowed; level interrupt, active low
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h0344, 1);
    s0 = susps;
    host_i.wr(`UDCR_CMD_MODE_WR, 16'h0020, 1);
    repeat (SUSP + 10) @(posedge clk);
    chk({15'h0000, clocks_stopped}, 16'(susps - s0));
    host_i.wr(`UDCR_CMD_MODE_WR, 16'h0000, 1);
    repeat (5) @(posedge clk);
    chk({14'h0000, clocks_stopped, 1'b1}, 16'(susps - s0));
    repeat (SUSP + 5) @(posedge clk);
    chk({14'h0000, clocks_stopped, slow_clock_sel}, 16'h0003);
    // Clocks kept running and slow clock disabled while asleep
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h3344, 1);
    repeat (2) @(posedge clk);
    chk({14'h0000, clocks_stopped, slow_clock_sel}, 16'h0000);
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h0344, 1);
    host_i.wr(`UDCR_CMD_MODE_WR, 16'h0000, 1);
    repeat (3) @(posedge clk);
    chk(16'(clocks_stopped), 16'h0000);
    $display("suspend test done");
    for (int i = 0; i < 8; i++) begin
      host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h0344 | (i[1] ? 16'h4000 : 16'h0000), 1);
      host_i.wr(`UDCR_CMD_MODE_WR, {15'h0000, i[0]}, 1);
      dual_role_mode <= i[2];
      repeat (3) @(posedge clk);
      chk(16'(pullup_on), 16'(i == 1));
    end
    dual_role_mode <= 1'b0;
    $display("pull-up test done");
    irq(8'h08, 0, 1'b1);
    irq(8'h08, 3, 1'b1);
    irq(8'h08, 1, 1'b0);
    irq(8'h0c, 1, 1'b1);
    irq(8'h0c, 2, 1'b1);
    irq(8'h04, 2, 1'b0);
    irq(8'h00, 0, 1'b0);
    irq(8'h04, 4, 1'b0);
    irq(8'h08, 4, 1'b1);
    per(3);
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h0545, 1);
    pol = 1'b1;
    irq(8'h08, 0, 1'b1);
    per(5);
    host_i.wr(`UDCR_CMD_HWCFG_WR, 16'h0346, 1);
    host_i.wr(`UDCR_CMD_MODE_WR, 16'h0008, 1);
    ev <= 5'h01;
    @(posedge clk);
    ev <= 5'h00;
    w = 16'h0000;
    repeat (20) begin
      @(posedge clk);
      #1 w = w + 16'(int_out === 1'b0);
    end
    chk(w, 16'h0007);
    $display("interrupt and clock test done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
